// ### core/cco_core.sv
/*
  execution unit for jump-and-link, clock mode write and the two compares,
  with its register file, flags and program counter, reached over ahb-lite.
  assumes one master on a single-slave bus (hready_i is our hreadyout_o)
  and a hub slot counter that advances every clock.
*/
// The AHB-Lite interface to the registers and the address map were left to the implementer.
// Operation
// - jump-and-link first stores the next address into the exit register's source field
// - after the store, jump-and-link jumps to the address in its source field
// - the exit instruction branches to its own source field, the stored return address
// - no call stack; a second entry overwrites the stored return address
// - jump-and-link opcode with immediate bit; destination names the exit register
// - with the suppress-result effect jump-and-link stores nothing, a plain branch
// - only the low nine bits of the exit register change
// - clock mode write moves the low 8 bits of the destination register only as a hub op; otherwise it only advances the program counter
// - clock mode write is a hub op when the source is immediate zero
// - clock mode write changes only the clock mode, never a frequency value
// - hub ops complete in 7 to 22 clocks depending on the hub slot
// - unsigned compare takes a register or a 9-bit immediate second operand
// - with zero update, zero flag set on equal operands, else cleared
// - with carry update, carry set when first operand is unsigned-less
// - unsigned compare writes only with write-result, then stores the difference
// - unsigned compare carry follows unsigned magnitude for opposite signs
// - signed compare sets zero on equal, carry on signed less, takes 4 clocks
`include "cco_params.svh"
`timescale 1ns/100ps
`default_nettype none

module cco_core #(
  parameter int REG_DEPTH = 512,
  parameter logic [3:0] HUB_SLOT = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic [7:0] clock_mode_o,
  output logic busy_o
);

  // hub wait: 7 plus the clocks until our slot comes round
  function automatic logic [4:0] hub_latency(input logic [3:0] phase);
    hub_latency = `CCO_LAT_HUB_MIN + {1'b0, 4'(HUB_SLOT - phase)};
  endfunction

  // clock mode write counts as a hub op only with immediate zero source
  function automatic logic is_hub(input cco_pkg::cco_instr_t ins);
    is_hub = (ins.op == `CCO_OP_CLOCK_MODE_WRITE) && ins.imm &&
             (ins.src == `CCO_HUB_MARK);
  endfunction

  logic [31:0] rf [REG_DEPTH];
  cco_pkg::cco_aphase_t aph_r;
  cco_pkg::cco_state_t state_r;
  cco_pkg::cco_instr_t ir_r;
  cco_pkg::cco_instr_t issue_word;
  logic [31:0] last_word_r;
  logic [4:0] cnt_r;
  logic [3:0] hub_phase_r;
  logic [8:0] pc_r;
  logic [8:0] rf_addr_r;
  logic z_r;
  logic c_r;
  logic [7:0] clk_mode_r;
  logic bus_wr_go;
  logic bus_rd_go;
  logic issue;
  logic apply;
  logic [31:0] d_val;
  logic [31:0] s_val;
  logic [32:0] diff;
  logic [8:0] pc_ret;
  logic is_jal;
  logic is_cmp;
  logic cmp_less;
  logic [31:0] rd_mux;

  // bus data phase goes ahead; writes wait while an instruction runs
  assign bus_wr_go = aph_r.valid && aph_r.write && (state_r == cco_pkg::CCO_IDLE);
  assign bus_rd_go = aph_r.valid && !aph_r.write;
  assign issue = bus_wr_go &&
                 (aph_r.addr == `CCO_OFF_INSTR || aph_r.addr == `CCO_OFF_STEP);
  assign issue_word = (aph_r.addr == `CCO_OFF_INSTR) ? hwdata_i : rf[pc_r];
  assign apply = (state_r == cco_pkg::CCO_EXEC) && (cnt_r == 5'h00);

  // operands of the running instruction
  assign d_val = rf[ir_r.dest];
  assign s_val = ir_r.imm ? {23'h00_0000, ir_r.src} : rf[ir_r.src];
  assign diff = {1'b0, d_val} - {1'b0, s_val};
  assign pc_ret = 9'(pc_r + 9'h001);
  assign is_jal = (ir_r.op == `CCO_OP_JUMP_AND_LINK);
  assign is_cmp = (ir_r.op == `CCO_OP_COMPARE_UNSIGNED) ||
                  (ir_r.op == `CCO_OP_COMPARE_SIGNED);

  // carry source: borrow for unsigned, signed less for signed
  always_comb begin
    if (ir_r.op == `CCO_OP_COMPARE_SIGNED) begin
      cmp_less = $signed(d_val) < $signed(s_val);
    end else begin
      cmp_less = diff[32];
    end
  end

  // read data selection
  always_comb begin
    unique case (aph_r.addr)
      `CCO_OFF_INSTR: rd_mux = last_word_r;
      `CCO_OFF_PC: rd_mux = {23'h00_0000, pc_r};
      `CCO_OFF_FLAGS: rd_mux = {29'h0000_0000, busy_o, c_r, z_r};
      `CCO_OFF_CLKMODE: rd_mux = {24'h00_0000, clk_mode_r};
      `CCO_OFF_RF_ADDR: rd_mux = {23'h00_0000, rf_addr_r};
      `CCO_OFF_RF_DATA: rd_mux = rf[rf_addr_r];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture; every transfer gets one wait state, writes more while an instruction runs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aph_r <= '0;
    end else if (hready_i && hsel_i && htrans_i[1]) begin
      aph_r.valid <= 1'b1;
      aph_r.write <= hwrite_i;
      aph_r.addr <= haddr_i[7:0];
    end else if (bus_wr_go || bus_rd_go) begin
      aph_r.valid <= 1'b0;
    end
  end

  // ready, response and read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      hresp_o <= 1'b0;
      if (hready_i && hsel_i && htrans_i[1]) begin
        hreadyout_o <= 1'b0;
      end else if (bus_wr_go || bus_rd_go) begin
        hreadyout_o <= 1'b1;
      end
      if (bus_rd_go) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // free-running hub slot phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hub_phase_r <= 4'h0;
    end else begin
      hub_phase_r <= 4'(hub_phase_r + 4'h1);
    end
  end

  // instruction sequencing and latency count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= cco_pkg::CCO_IDLE;
      ir_r <= '0;
      cnt_r <= 5'h00;
      busy_o <= 1'b0;
      last_word_r <= `CCO_RST_WORD;
    end else begin
      unique case (state_r)
        cco_pkg::CCO_IDLE: begin
          if (issue) begin
            state_r <= cco_pkg::CCO_EXEC;
            busy_o <= 1'b1;
            ir_r <= issue_word;
            last_word_r <= issue_word;
            if (is_hub(issue_word)) begin
              cnt_r <= 5'(hub_latency(hub_phase_r) - 5'h01);
            end else begin
              cnt_r <= 5'(`CCO_LAT_ALU - 5'h01);
            end
          end
        end
        cco_pkg::CCO_EXEC: begin
          if (apply) begin
            state_r <= cco_pkg::CCO_IDLE;
            busy_o <= 1'b0;
          end else begin
            cnt_r <= 5'(cnt_r - 5'h01);
          end
        end
      endcase
    end
  end

  // program counter: jump target or next word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_r <= `CCO_RST_PC;
    end else if (apply) begin
      if (is_jal) begin
        pc_r <= s_val[8:0];
      end else begin
        pc_r <= pc_ret;
      end
    end else if (bus_wr_go && aph_r.addr == `CCO_OFF_PC) begin
      pc_r <= hwdata_i[8:0];
    end
  end

  // register file: return address, compare difference, bus writes
  always_ff @(posedge clk_i) begin
    if (apply && is_jal && ir_r.write_result) begin
      rf[ir_r.dest] <= {d_val[31:9], pc_ret};
    end else if (apply && is_cmp && ir_r.write_result) begin
      rf[ir_r.dest] <= diff[31:0];
    end else if (bus_wr_go && aph_r.addr == `CCO_OFF_RF_DATA) begin
      rf[rf_addr_r] <= hwdata_i;
    end
  end

  // register file index for software access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rf_addr_r <= 9'h000;
    end else if (bus_wr_go && aph_r.addr == `CCO_OFF_RF_ADDR) begin
      rf_addr_r <= hwdata_i[8:0];
    end
  end

  // zero and carry flags, each under its own effect bit; a bus write to the flags sets both
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      z_r <= 1'b0;
      c_r <= 1'b0;
    end else if (apply && is_cmp) begin
      if (ir_r.zero_flag_update) begin
        z_r <= (d_val == s_val);
      end
      if (ir_r.carry_flag_update) begin
        c_r <= cmp_less;
      end
    end else if (apply && is_jal) begin
      if (ir_r.zero_flag_update) begin
        z_r <= (pc_ret == 9'h000);
      end
      if (ir_r.carry_flag_update) begin
        c_r <= (pc_ret != 9'h000);
      end
    end else if (bus_wr_go && aph_r.addr == `CCO_OFF_FLAGS) begin
      z_r <= hwdata_i[`CCO_FLAG_Z];
      c_r <= hwdata_i[`CCO_FLAG_C];
    end
  end

  // clock mode: only the mode byte, no frequency store
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_mode_r <= `CCO_RST_CLKMODE;
      clock_mode_o <= `CCO_RST_CLKMODE;
    end else if (apply && is_hub(ir_r)) begin
      clk_mode_r <= d_val[7:0];
      clock_mode_o <= d_val[7:0];
    end
  end

endmodule

`default_nettype wire

// ### core/cco_params.svh
/*
  constants for the call/clock/compare execution block: bus offsets,
  opcodes, flag register bit positions and cycle counts.
  assumes inclusion by bare name from package and core files.
*/
`ifndef CCO_PARAMS_SVH
`define CCO_PARAMS_SVH

// register byte offsets (low address byte)
`define CCO_OFF_INSTR 8'h00
`define CCO_OFF_STEP 8'h04
`define CCO_OFF_PC 8'h08
`define CCO_OFF_FLAGS 8'h0C
`define CCO_OFF_CLKMODE 8'h10
`define CCO_OFF_RF_ADDR 8'h14
`define CCO_OFF_RF_DATA 8'h18

// flag register bit positions
`define CCO_FLAG_Z 0
`define CCO_FLAG_C 1
`define CCO_FLAG_BUSY 2

// opcodes (instr field)
`define CCO_OP_JUMP_AND_LINK 6'h17
`define CCO_OP_CLOCK_MODE_WRITE 6'h03
`define CCO_OP_COMPARE_UNSIGNED 6'h21
`define CCO_OP_COMPARE_SIGNED 6'h30

// hub op marker carried in the source field
`define CCO_HUB_MARK 9'h000

// execution cycle counts
`define CCO_LAT_ALU 5'h04
`define CCO_LAT_HUB_MIN 5'h07

// reset values
`define CCO_RST_WORD 32'h0000_0000
`define CCO_RST_PC 9'h000
`define CCO_RST_CLKMODE 8'h00

`endif

// ### core/cco_pkg.sv
/*
  types shared by the call/clock/compare execution block.
  assumes cco_params.svh is on the include path.
*/
`include "cco_params.svh"

package cco_pkg;

  // one instruction word, msb first
  typedef struct packed {
    logic [5:0] op;
    logic zero_flag_update;
    logic carry_flag_update;
    logic write_result;
    logic imm;
    logic [3:0] cond;
    logic [8:0] dest;
    logic [8:0] src;
  } cco_instr_t;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } cco_aphase_t;

  typedef enum logic [0:0] {
    CCO_IDLE,
    CCO_EXEC
  } cco_state_t;

endpackage

// ### dv/cco_hub_model.sv
/* far-side meter: measures how many clocks each instruction holds the core busy.
   assumes one clock and busy_i from the core under test. */
`timescale 1ns/100ps
`default_nettype none
module cco_hub_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic busy_i,
  output logic [4:0] len_o
);
  logic [4:0] cnt_r;
  // count busy clocks, publish the count when busy drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      len_o <= 5'h00;
    end else if (busy_i) begin
      cnt_r <= cnt_r + 5'h01;
    end else if (cnt_r != 5'h00) begin
      len_o <= cnt_r;
      cnt_r <= 5'h00;
    end
  end
endmodule
`default_nettype wire

// ### dv/cco_core_asserts.sv
/* port assertions for the execution block.
   assumes a bind onto cco_core and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module cco_core_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [7:0] clock_mode_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk;
  // a transfer is taken at this edge
  assign tk = hsel_i && htrans_i[1] && hready_i;
  a_resp_okay: assert property (hresp_o == 1'h0) else $error("error response seen");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*4])
    else $error("busy shorter than 4");
  a_busy_max: assert property ($rose(busy_o) |-> ##[4:22] !busy_o)
    else $error("busy longer than 22");
  a_clk_land: assert property ($changed(clock_mode_o) |-> $fell(busy_o))
    else $error("clock mode moved outside completion");
  a_clk_late: assert property ($changed(clock_mode_o) |-> $past(busy_o, 7))
    else $error("clock mode faster than 7");
  a_rd_wait: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_wr_wait: assert property (tk && hwrite_i |=> !hreadyout_o)
    else $error("write not stalled");
  a_issue_src: assert property ($rose(busy_o) |-> !$past(hreadyout_o))
    else $error("issue outside write data phase");
  c_exec: cover property ($rose(busy_o));
  c_clk: cover property ($changed(clock_mode_o));
  c_read: cover property (tk && !hwrite_i);
endmodule
bind cco_core cco_core_asserts u_cco_core_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .clock_mode_o(clock_mode_o),
  .busy_o(busy_o));
`default_nettype wire

// ### dv/tb_top.sv
/* self-checking bench for the execution block over ahb-lite.
   assumes the block is the only slave and the bench the only master. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, r, w;
  wire logic rdy, resp, busy;
  wire logic [31:0] hrdata;
  wire logic [7:0] cmode;
  wire logic [4:0] len;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [31:0] dv [4] = '{32'h0000_0003, 32'h0000_0003, 32'h8000_0000, 32'h7FFF_FFFF};
  logic [31:0] sv [4] = '{32'h0000_0004, 32'h0000_0003, 32'h7FFF_FFFF, 32'h8000_0000};
  cco_core u_cco_core (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(resp), .hrdata_o(hrdata),
    .clock_mode_o(cmode), .busy_o(busy));
  cco_hub_model u_cco_hub_model (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy), .len_o(len));
  initial forever #50 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // one single ahb transfer, address then data phase
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    hsel_i <= 1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= wr;
    do @(posedge clk_i); while (rdy !== 1'b1);
    hsel_i <= 0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (rdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic exec(logic [7:0] a, logic [31:0] d);
    xfer(1, a, d);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic setr(logic [8:0] i, logic [31:0] d);
    xfer(1, 8'h14, {23'h0, i});
    xfer(1, 8'h18, d);
  endtask
  task automatic getr(logic [8:0] i);
    xfer(1, 8'h14, {23'h0, i});
    xfer(0, 8'h18, 32'h0);
  endtask
  function automatic logic [31:0] mk(logic [5:0] op, logic z, c, wr, im, logic [8:0] d, s);
    cco_pkg::cco_instr_t x;
    x = '{op, z, c, wr, im, 4'hF, d, s};
    return x;
  endfunction
  task automatic rflags();
    xfer(0, 8'h0C, 32'h0);
    r = r & 32'h0000_0003;
  endtask
  task automatic t_cmp();
    logic [5:0] op;
    for (int k = 0; k < 8; k++) begin
      op = k[0] ? 6'h30 : 6'h21;
      setr(1, dv[k/2]);
      setr(2, sv[k/2]);
      exec(8'h00, mk(op, 1, 1, 0, 0, 1, 2));
      chk("cmp_len", {27'h0, len}, 32'h4);
      w = k[0] ? ($signed(dv[k/2]) < $signed(sv[k/2])) : (dv[k/2] < sv[k/2]);
      rflags();
      chk("cmp_flags", r, {w[0], dv[k/2] == sv[k/2]});
      getr(1);
      chk("cmp_nowrite", r, dv[k/2]);
      exec(8'h00, mk(op, 0, 0, 1, 0, 1, 2));
      getr(1);
      chk("cmp_diff", r, dv[k/2] - sv[k/2]);
      rflags();
      chk("cmp_keep", r, {w[0], dv[k/2] == sv[k/2]});
    end
    setr(1, 32'h0000_0005);
    exec(8'h00, mk(6'h21, 1, 1, 0, 1, 1, 9'h005));
    rflags();
    chk("cmp_imm", r, 32'h1);
    $display("t_cmp done");
  endtask
  task automatic t_call();
    w = mk(6'h17, 0, 0, 0, 1, 0, 0);
    setr(5, w);
    xfer(1, 8'h08, 32'h10);
    exec(8'h00, mk(6'h17, 1, 1, 1, 1, 5, 9'h040));
    xfer(0, 8'h08, 0);
    chk("call_pc", r, 32'h40);
    getr(5);
    chk("call_link", r, w | 32'h11);
    rflags();
    chk("call_flags", r, 32'h2);
    xfer(1, 8'h08, 32'h20);
    exec(8'h00, mk(6'h17, 0, 0, 1, 1, 5, 9'h040));
    getr(5);
    chk("call_again", r, w | 32'h21);
    xfer(1, 8'h08, 32'h5);
    exec(8'h04, 0);
    xfer(0, 8'h08, 0);
    chk("ret_pc", r, 32'h21);
    exec(8'h00, mk(6'h17, 0, 0, 0, 1, 5, 9'h050));
    xfer(0, 8'h08, 0);
    chk("jmp_pc", r, 32'h50);
    getr(5);
    chk("jmp_keep", r, w | 32'h21);
    $display("t_call done");
  endtask
  task automatic t_clk();
    setr(3, 32'h0000_016F);
    xfer(1, 8'h0C, 1);
    exec(8'h00, mk(6'h03, 1, 1, 1, 1, 3, 9'h000));
    chk("clk_mode", {24'h0, cmode}, 32'h6F);
    chk("hub_len", (len >= 7 && len <= 22), 1);
    getr(3);
    // the frequency store to main memory is software's job; mode source word stays intact
    chk("clk_rf", r, 32'h0000_016F);
    rflags();
    chk("clk_flags", r, 32'h1);
    setr(3, 32'h0000_0022);
    exec(8'h00, mk(6'h03, 0, 0, 0, 0, 3, 9'h000));
    chk("clk_noimm", {24'h0, cmode}, 32'h6F);
    chk("noimm_len", {27'h0, len}, 32'h4);
    $display("t_clk done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_cmp();
    t_call();
    t_clk();
    end_sim();
  end
endmodule
`default_nettype wire
